// ---- hw/imc_master.sv ----
`timescale 1ns/1ps
// Operation
// - Master only; no slave-mode logic exists.
// - Baud reload floor keeps the bus at or below 400 kbit/s.
// - Software sends 7- or 10-bit address bytes; read bit steers direction.
// - Whole bytes only, no limit on count per transfer.
// - Single master, no arbitration hardware.
// - Address, data and acknowledge bits go MSB first on the data line.
// - Pins are open drain: only ever pulled low, else released.
// - Release clock after low phase; wait while the slave holds it low.
// - Data changes mid clock-low; input sampled mid clock-high.
// - Transmit, receive, nack and timer events merge into one request.
// - Transmit and timer sources gated by their own enable combination; receive and nack by controller enable alone.
// - Nack flag sets on nack only while no start or stop is requested.
// - Nack flag clears on start or stop request; bus waits till then.
// - Receive-full sets during acknowledge phase, clears on data read.
// - After acknowledge of a received byte, stall until receive-full clears.
// - Transmit interrupt is transmit-empty with transmit enable.
// - Transmit-empty sets on enable, first address, 10-bit and data bits.
// - A data write or flush clears transmit-empty, unless it sets in that cycle.
// - Transmit-empty holds at acknowledge start until data, start or stop.
// - Disabled with timer select, counter reaching one raises interrupt.
// - Start is data falling while clock is high.
// - Stop is data rising while clock is high.
// - Start waits for start request and a written data byte.
// - Stop request clears once the stop is on the bus.
module imc_master #(
	parameter int FIFO_W = 8,
	parameter int FIFO_D = imc_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire imc_pkg::imc_ctrl_t ctrl,
	input wire logic start_set,
	input wire logic stop_set,
	input wire logic flush,
	input wire logic data_wr,
	input wire logic [7:0] data_wdata,
	output logic data_wr_ready,
	input wire logic data_rd,
	output logic [7:0] rx_data,
	output imc_pkg::imc_stat_t status,
	output logic irq,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	import imc_pkg::*;

	initial begin
		if (FIFO_W != BYTE_W)
			$error("imc_master fifo width must be one byte");
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] scl_s_r;
	logic [2:0] sda_s_r;
	logic scl_f_r;
	logic sda_f_r;

	// Three flops; a level counts once the last two agree
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			scl_s_r <= 3'h7;
			sda_s_r <= 3'h7;
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
		end else if (ce) begin
			scl_s_r <= {scl_s_r[1:0], scl_in};
			sda_s_r <= {sda_s_r[1:0], sda_in};
			if (scl_s_r[1] == scl_s_r[2])
				scl_f_r <= scl_s_r[2];
			if (sda_s_r[1] == sda_s_r[2])
				sda_f_r <= sda_s_r[2];
		end
	end

	// ------------------------------------------------------------
	// Transmit byte buffer
	// ------------------------------------------------------------
	logic fifo_valid;
	logic fifo_pop;
	logic [7:0] fifo_data;

	imc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_txq (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.flush(flush),
		.in_valid(data_wr),
		.in_ready(data_wr_ready),
		.in_data(data_wdata),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// ------------------------------------------------------------
	// Baud counter
	// ------------------------------------------------------------
	logic [15:0] baud_counter_r;
	logic [15:0] reload;
	logic tick;

	assign reload = (ctrl.baud_reload < 16'(MIN_QUARTER_CYC) &&
		ctrl.controller_enable) ? 16'(MIN_QUARTER_CYC) : ctrl.baud_reload;
	assign tick = (baud_counter_r == 16'h0001);

	// quarter-bit tick from the reload value
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			baud_counter_r <= BAUD_RESET;
		else if (ce) begin
			if (tick || baud_counter_r == 16'h0000)
				baud_counter_r <= reload;
			else
				baud_counter_r <= baud_counter_r - 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Software request bits
	// ------------------------------------------------------------
	logic start_r;
	logic stop_r;
	logic stop_done;
	logic start_taken;

	// stop request cleared by hardware when stop is done
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			start_r <= 1'b0;
			stop_r <= 1'b0;
		end else if (ce) begin
			if (start_set)
				start_r <= 1'b1;
			else if (start_taken)
				start_r <= 1'b0;
			if (stop_set)
				stop_r <= 1'b1;
			else if (stop_done)
				stop_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Bus sequencer
	// ------------------------------------------------------------
	imc_state_t state_r;
	logic [1:0] ph_r;
	logic [2:0] bit_r;
	logic [7:0] shift_r;
	logic reading_r;
	logic addr_phase_r;
	logic ten_r;
	logic scl_lo_r;
	logic sda_lo_r;
	logic ack_r;
	logic nack_r;
	logic rxf_r;
	logic txe_r;
	logic [7:0] rx_r;
	logic rd_req_r;
	logic nack_ev;
	logic txe_ev;
	logic en_d_r;
	logic stretch;

	// start needs request and a queued byte
	assign start_taken = (state_r == ST_IDLE || state_r == ST_HOLD) &&
		start_r && fifo_valid && !rxf_r && tick;
	// released clock still low means the slave stretches
	assign stretch = !scl_lo_r && !scl_f_r;
	assign stop_done = (state_r == ST_STOP_C) && tick;
	assign fifo_pop = ce && tick && fifo_valid &&
		((state_r == ST_START_B) ||
		(state_r == ST_ACK_WAIT && !reading_r));

	// Sequencer, one quarter-bit phase per tick
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			ph_r <= 2'h0;
			bit_r <= 3'h7;
			shift_r <= 8'h00;
			reading_r <= 1'b0;
			addr_phase_r <= 1'b0;
			ten_r <= 1'b0;
			rd_req_r <= 1'b0;
			scl_lo_r <= 1'b0;
			sda_lo_r <= 1'b0;
			ack_r <= 1'b0;
			rx_r <= 8'h00;
		end else if (ce && !ctrl.controller_enable) begin
			state_r <= ST_IDLE;
			scl_lo_r <= 1'b0;
			sda_lo_r <= 1'b0;
		end else if (ce && tick && !stretch) begin
			ph_r <= ph_r + 2'h1;
			case (state_r)
				ST_IDLE, ST_HOLD: begin
					ph_r <= 2'h0;
					if (start_taken) begin
						scl_lo_r <= 1'b0;
						sda_lo_r <= 1'b0;
						state_r <= ST_START_A;
					end else if (stop_r && !nack_r) begin
						state_r <= ST_STOP_A;
					end else if (nack_r && stop_r) begin
						state_r <= ST_STOP_A;
					end else if (state_r == ST_HOLD && reading_r &&
						!rxf_r && !nack_r) begin
						// read on once software took the byte
						state_r <= ST_BIT_LO;
					end
				end
				ST_START_A: begin
					sda_lo_r <= 1'b1;
					state_r <= ST_START_B;
				end
				ST_START_B: begin
					// address byte, read bit picks direction
					scl_lo_r <= 1'b1;
					shift_r <= fifo_data;
					ten_r <= (fifo_data[7:3] == TEN_BIT_PREFIX) &&
						!fifo_data[RW_BIT];
					reading_r <= 1'b0;
					rd_req_r <= fifo_data[RW_BIT];
					addr_phase_r <= 1'b1;
					bit_r <= 3'h7;
					ph_r <= 2'h0;
					state_r <= ST_BIT_LO;
				end
				ST_BIT_LO: begin
					if (ph_r == 2'h0)
						sda_lo_r <= !reading_r && !shift_r[7];
					if (ph_r == 2'h1) begin
						scl_lo_r <= 1'b0;
						state_r <= ST_BIT_HI;
						ph_r <= 2'h0;
					end
				end
				ST_BIT_HI: begin
					// data line never compared, no arbitration
					if (ph_r == 2'h0 && reading_r)
						rx_r <= {rx_r[6:0], sda_f_r};
					if (ph_r == 2'h1) begin
						scl_lo_r <= 1'b1;
						ph_r <= 2'h0;
						shift_r <= {shift_r[6:0], 1'b0};
						bit_r <= bit_r - 3'h1;
						state_r <= (bit_r == 3'h0) ? ST_ACK_WAIT : ST_BIT_LO;
					end
				end
				ST_ACK_WAIT: begin
					// pause while transmit empty and no request
					ph_r <= 2'h0;
					if (reading_r || !txe_r || start_r || stop_r) begin
						if (fifo_valid && !reading_r)
							shift_r <= fifo_data;
						state_r <= ST_ACK_LO;
					end
				end
				ST_ACK_LO: begin
					if (ph_r == 2'h0)
						sda_lo_r <= reading_r && !ctrl.nak_last;
					if (ph_r == 2'h1) begin
						scl_lo_r <= 1'b0;
						ph_r <= 2'h0;
						state_r <= ST_ACK_HI;
					end
				end
				ST_ACK_HI: begin
					if (ph_r == 2'h0 && !reading_r)
						ack_r <= !sda_f_r;
					if (ph_r == 2'h1) begin
						scl_lo_r <= 1'b1;
						ph_r <= 2'h0;
						// next whole byte, no count limit
						bit_r <= 3'h7;
						if (addr_phase_r && !ten_r && !reading_r)
							reading_r <= rd_req_r;
						addr_phase_r <= addr_phase_r && ten_r;
						ten_r <= 1'b0;
						if (nack_ev || start_r || stop_r || (reading_r && rxf_r))
							state_r <= ST_HOLD;
						else
							state_r <= ST_BIT_LO;
					end
				end
				ST_STOP_A: begin
					// data low, then clock high, then data rises
					scl_lo_r <= 1'b1;
					sda_lo_r <= 1'b1;
					state_r <= ST_STOP_B;
				end
				ST_STOP_B: begin
					scl_lo_r <= 1'b0;
					state_r <= ST_STOP_C;
				end
				ST_STOP_C: begin
					sda_lo_r <= 1'b0;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Nack seen at the end of an acknowledge slot
	assign nack_ev = ce && tick && !stretch && state_r == ST_ACK_HI &&
		ph_r == 2'h1 &&
		(reading_r ? ctrl.nak_last : sda_f_r);
	// first bit of a byte leaving while buffer empty
	assign txe_ev = ce && ((ctrl.controller_enable && !en_d_r) ||
		(tick && state_r == ST_BIT_LO && ph_r == 2'h0 &&
		bit_r == 3'h7 && !reading_r && !(addr_phase_r && rd_req_r) &&
		!fifo_valid));

	// ------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			nack_r <= 1'b0;
			rxf_r <= 1'b0;
			txe_r <= 1'b0;
			en_d_r <= 1'b0;
		end else if (ce) begin
			en_d_r <= ctrl.controller_enable;
			// set wins; only without start or stop pending
			// start or stop request clears it
			if (nack_ev && !start_r && !stop_r)
				nack_r <= 1'b1;
			else if (start_set || stop_set)
				nack_r <= 1'b0;
			// set in acknowledge phase, read clears
			if (state_r == ST_ACK_LO && reading_r && ph_r == 2'h0 && tick)
				rxf_r <= 1'b1;
			else if (data_rd)
				rxf_r <= 1'b0;
			if (txe_ev && !fifo_valid)
				txe_r <= 1'b1;
			else if (data_wr || flush)
				txe_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	// open drain: oe high only while pulling low
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			scl_out <= 1'b0;
			scl_oe <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			irq <= 1'b0;
			rx_data <= 8'h00;
			status <= '0;
		end else if (ce) begin
			scl_oe <= scl_lo_r;
			sda_oe <= sda_lo_r;
			rx_data <= rx_r;
			irq <= (ctrl.controller_enable &&
				((txe_r && ctrl.tx_irq_enable) || rxf_r || nack_r)) ||
				(!ctrl.controller_enable && ctrl.timer_irq_select && tick);
			status <= '{nack_flag: nack_r, rx_full_flag: rxf_r,
				tx_empty_flag: txe_r, ack_seen: ack_r,
				start_pend: start_r, stop_pend: stop_r,
				busy: state_r != ST_IDLE};
		end
	end
endmodule

// ---- hw/imc_pkg.sv ----
package imc_pkg;
	// Baud reload width and reset reload
	localparam int BAUD_W = 16;
	localparam logic [15:0] BAUD_RESET = 16'h0001;
	// Bus rate ceiling and timing
	localparam int MAX_RATE_KBPS = 400;
	localparam int CLK_PERIOD_PS = 5000;
	// Least reload that keeps a quarter bit at or below max rate
	localparam int MIN_QUARTER_CYC =
		(1000000000 / (MAX_RATE_KBPS * 4) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Data byte width and field positions of an address byte
	localparam int BYTE_W = 8;
	localparam int RW_BIT = 0;
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
	localparam int FIFO_DEPTH = 8;

	// Software control word
	typedef struct packed {
		logic controller_enable;
		logic tx_irq_enable;
		logic timer_irq_select;
		logic nak_last;
		logic [15:0] baud_reload;
	} imc_ctrl_t;

	// Status word shown to software
	typedef struct packed {
		logic nack_flag;
		logic rx_full_flag;
		logic tx_empty_flag;
		logic ack_seen;
		logic start_pend;
		logic stop_pend;
		logic busy;
	} imc_stat_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_START_A, ST_START_B, ST_BIT_LO, ST_BIT_HI,
		ST_ACK_WAIT, ST_ACK_LO, ST_ACK_HI, ST_HOLD,
		ST_STOP_A, ST_STOP_B, ST_STOP_C
	} imc_state_t;
endpackage

// ---- hw/imc_fifo.sv ----
`timescale 1ns/1ps
module imc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("imc_fifo depth must be a power of two");
	end

	// Honest full and empty from the occupancy count
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage
	always_ff @(posedge mclk) begin
		if (ce && push)
			mem[wp_r] <= in_data;
	end

	// Pointers and count
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else if (ce) begin
			if (flush) begin
				wp_r <= '0;
				rp_r <= '0;
				cnt_r <= '0;
			end else begin
				if (push)
					wp_r <= wp_r + 1'b1;
				if (pop)
					rp_r <= rp_r + 1'b1;
				if (push && !pop)
					cnt_r <= cnt_r + 1'b1;
				else if (pop && !push)
					cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule

// ---- sim/imc_assertions.sv ----
`timescale 1ns/1ps
module imc_assertions (
	input wire logic mclk,
	input wire logic nrst,
	input wire imc_pkg::imc_ctrl_t ctrl,
	input wire logic start_set,
	input wire logic stop_set,
	input wire imc_pkg::imc_stat_t status,
	input wire logic irq,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe
);
	import imc_pkg::*;
	logic [15:0] gap_r;
	logic seen_r;
	logic timer_mode;

	// Timer mode: controller off, timer source picked
	assign timer_mode = !ctrl.controller_enable && ctrl.timer_irq_select;

	// Cycles since the last request pulse
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			gap_r <= 16'h0000;
		else if (irq)
			gap_r <= 16'h0001;
		else
			gap_r <= gap_r + 16'h0001;
	end

	// First pulse in timer mode has an unknown phase, so skip it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			seen_r <= 1'b0;
		else if (!timer_mode)
			seen_r <= 1'b0;
		else if (irq)
			seen_r <= 1'b1;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	// ----
	// Bus framing
	// ----
	sequence s_start;
		$rose(sda_oe) && !scl_oe;
	endsequence
	sequence s_stop;
		$fell(sda_oe) && !scl_oe;
	endsequence

	a_pins_open_drain: assert property (
		!scl_out && !sda_out) else $error("pin driven high");
	a_start_then_clock: assert property (
		s_start |-> ##[1:400] scl_oe) else $error("no clock after start");
	a_stop_clears_req: assert property (
		s_stop |-> ##[1:400] !status.stop_pend) else $error("stop kept");
	a_edge_data_quiet: assert property (
		$changed(scl_oe) |=> $stable(sda_oe) [*8])
		else $error("data moved at clock edge");
	a_stretch_wait: assert property (
		!scl_oe && !scl_in |=> !scl_oe) else $error("clock pulled early");

	// ----
	// Request output
	// ----
	a_tx_irq_gate: assert property (
		(status.tx_empty_flag && ctrl.controller_enable &&
		ctrl.tx_irq_enable) [*3] |-> irq) else $error("tx request lost");
	a_irq_quiet_off: assert property (
		(!ctrl.controller_enable && !ctrl.timer_irq_select) [*3] |-> !irq)
		else $error("request while off");
	a_nack_freeze: assert property (
		status.nack_flag && $past(status.nack_flag) && !start_set &&
		!stop_set && !$past(start_set) && !$past(stop_set)
		|=> $stable(scl_oe) && $stable(sda_oe)) else $error("bus moved");
	a_timer_period: assert property (
		irq && seen_r && timer_mode |-> gap_r == ctrl.baud_reload)
		else $error("timer period wrong");
endmodule

bind imc_master imc_assertions imc_assertions_inst (.mclk, .nrst, .ctrl,
	.start_set, .stop_set, .status, .irq, .scl_in, .scl_out, .scl_oe,
	.sda_out, .sda_oe);

// ---- sim/imc_slave_model.sv ----
`timescale 1ns/1ps
module imc_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic ack_en,
	input wire logic stretch_en,
	input wire logic [7:0] rd_data,
	output logic scl_pull,
	output logic sda_pull,
	output logic [7:0] last_byte,
	output int byte_count
);
	logic [7:0] shift_r;
	int bit_cnt;
	logic rd_mode;
	logic first_byte;

	// ----
	// Behavioural slave, pulls lines low only
	// ----
	initial begin
		{scl_pull, sda_pull, last_byte, shift_r} = '0;
		bit_cnt = 0;
		byte_count = 0;
		rd_mode = 1'b0;
		first_byte = 1'b0;
	end

	// start restarts count; first byte is the address
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			bit_cnt = 0;
			rd_mode = 1'b0;
			first_byte = 1'b1;
		end
	end

	// first bit is MSB; a master nack ends a read
	always @(posedge scl) begin
		if (bit_cnt < 8) shift_r = {shift_r[6:0], sda};
		if (bit_cnt == 8 && rd_mode && sda) rd_mode = 1'b0;
		bit_cnt = bit_cnt + 1;
	end

	// hold clock low past the master's low phase
	always @(negedge scl) begin
		if (bit_cnt == 8) begin
			last_byte = shift_r;
			byte_count = byte_count + 1;
			sda_pull = ack_en && !rd_mode;
			if (first_byte) rd_mode = shift_r[0];
			first_byte = 1'b0;
			if (stretch_en) begin
				scl_pull = 1'b1;
				#2000;
				scl_pull = 1'b0;
			end
		end else if (bit_cnt == 9) begin
			sda_pull = rd_mode && !rd_data[7];
			bit_cnt = 0;
		end else if (rd_mode && bit_cnt > 0) begin
			sda_pull = !rd_data[7 - bit_cnt];
		end
	end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import imc_pkg::*;
	logic mclk, nrst;
	imc_ctrl_t ctrl;
	imc_stat_t status;
	logic start_set, stop_set, flush, data_wr, data_rd;
	logic [7:0] data_wdata, rx_data, last_byte;
	logic data_wr_ready, irq, scl_out, scl_oe, sda_out, sda_oe;
	logic scl_pull, sda_pull, ack_en, stretch_en, scl_line, sda_line;
	int byte_count, num_errors, samples_checked, i, n;

	// Open-drain lines with pull-ups
	assign scl_line = !(scl_oe || scl_pull);
	assign sda_line = !(sda_oe || sda_pull);

	// 200 MHz clock
	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;

	imc_master imc_master_inst (.mclk, .nrst, .ce(1'b1), .ctrl, .start_set,
		.stop_set, .flush, .data_wr, .data_wdata, .data_wr_ready, .data_rd,
		.rx_data, .status, .irq, .scl_in(scl_line), .scl_out, .scl_oe,
		.sda_in(sda_line), .sda_out, .sda_oe);
	imc_slave_model imc_slave_model_inst (.scl(scl_line), .sda(sda_line),
		.ack_en, .stretch_en, .rd_data(8'h6B), .scl_pull, .sda_pull,
		.last_byte, .byte_count);

	// ----
	// Shared tasks
	// ----
	task check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value at %0t: %0h not %0h", $time, seen, want);
		end
	endtask

	task cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask

	task put(input logic [7:0] b);
		@(posedge mclk);
		data_wr <= 1'b1;
		data_wdata <= b;
		@(posedge mclk);
		data_wr <= 1'b0;
	endtask

	task req(input logic st, input logic sp, input logic fl);
		@(posedge mclk);
		start_set <= st;
		stop_set <= sp;
		flush <= fl;
		@(posedge mclk);
		start_set <= 1'b0;
		stop_set <= 1'b0;
		flush <= 1'b0;
	endtask

	// Bounded waits; a run-out shows as a mismatch, in the caller for wait_bytes and inside wait_stop itself
	task wait_bytes(input int k);
		for (i = 0; i < 20000 && byte_count < k; i++) @(posedge mclk);
	endtask

	task wait_stop;
		cyc(3);
		for (i = 0; i < 20000 && status.stop_pend !== 1'b0; i++)
			@(posedge mclk);
		check(status.stop_pend, 1'b0);
	endtask

	task count_irq(input int k);
		n = 0;
		repeat (k) begin
			@(negedge mclk);
			if (irq === 1'b1) n++;
		end
		@(posedge mclk);
	endtask

	// ----
	// Scenarios
	// ----
	task t_timer;
		cyc(50);
		count_irq(200);
		check(n, 10);
		ctrl.timer_irq_select <= 1'b0;
		cyc(30);
		count_irq(100);
		check(n, 0);
	endtask

	task t_fill;
		ctrl.controller_enable <= 1'b1;
		ctrl.tx_irq_enable <= 1'b1;
		ctrl.baud_reload <= 16'h007D;
		cyc(5);
		check(status.tx_empty_flag, 1'b1);
		check(irq, 1'b1);
		ctrl.tx_irq_enable <= 1'b0;
		cyc(4);
		check(irq, 1'b0);
		for (n = 0; n < 9; n++) put(8'hC0 | 8'(n));
		cyc(2);
		check(data_wr_ready, 1'b0);
		check(status.tx_empty_flag, 1'b0);
		check(sda_oe, 1'b0);
		req(1'b0, 1'b0, 1'b1);
		cyc(3);
		check(data_wr_ready, 1'b1);
		check(status.tx_empty_flag, 1'b0);
	endtask

	// Slave stretches each ack; no next byte, so the master must pause
	task t_write;
		stretch_en <= 1'b1;
		put(8'hA4);
		put(8'h3C);
		req(1'b1, 1'b0, 1'b0);
		wait_bytes(1);
		check(last_byte, 8'hA4);
		wait_bytes(2);
		check(last_byte, 8'h3C);
		cyc(1500);
		check(byte_count, 2);
		check(status.busy, 1'b1);
		check(status.tx_empty_flag, 1'b1);
		stretch_en <= 1'b0;
		req(1'b0, 1'b1, 1'b0);
		wait_stop;
		cyc(500);
		check({scl_line, sda_line}, 2'b11);
	endtask

	task t_nack;
		ack_en <= 1'b0;
		put(8'h52);
		put(8'h11);
		req(1'b1, 1'b0, 1'b0);
		// poll nack before any transmit or receive handling
		for (i = 0; i < 20000 && status.nack_flag !== 1'b1; i++)
			@(posedge mclk);
		check(status.nack_flag, 1'b1);
		cyc(3);
		check(irq, 1'b1);
		cyc(2000);
		check(byte_count, 3);
		check(status.nack_flag, 1'b1);
		ack_en <= 1'b1;
		req(1'b0, 1'b1, 1'b1);
		cyc(3);
		check(status.nack_flag, 1'b0);
		wait_stop;
	endtask

	// Address-only probe with stop already requested
	task t_probe;
		ack_en <= 1'b0;
		put(8'h90);
		req(1'b1, 1'b1, 1'b0);
		wait_stop;
		check(status.nack_flag, 1'b0);
		check(byte_count, 4);
		check(status.ack_seen, 1'b0);
		check(status.tx_empty_flag, 1'b1);
		ack_en <= 1'b1;
	endtask

	// Read one byte from a 7-bit slave; master nacks it as the last
	task t_read;
		ctrl.nak_last <= 1'b1;
		put(8'hA5);
		req(1'b1, 1'b0, 1'b0);
		for (i = 0; i < 20000 && status.rx_full_flag !== 1'b1; i++)
			@(posedge mclk);
		check(status.rx_full_flag, 1'b1);
		check(rx_data, 8'h6B);
		cyc(2000);
		check(byte_count, 6);
		check(status.nack_flag, 1'b1);
		@(posedge mclk);
		data_rd <= 1'b1;
		@(posedge mclk);
		data_rd <= 1'b0;
		cyc(3);
		check(status.rx_full_flag, 1'b0);
		check(status.busy, 1'b1);
		req(1'b0, 1'b1, 1'b0);
		wait_stop;
		check(status.busy, 1'b0);
	endtask

	task give_verdict;
		$display("checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog: the scenarios need about half of this span
	initial begin
		#400000;
		num_errors++;
		give_verdict;
	end

	initial begin
		nrst = 1'b0;
		ctrl = '0;
		ctrl.timer_irq_select = 1'b1;
		ctrl.baud_reload = 16'h0014;
		{start_set, stop_set, flush, data_wr, data_rd} = '0;
		data_wdata = 8'h00;
		ack_en = 1'b1;
		stretch_en = 1'b0;
		num_errors = 0;
		samples_checked = 0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		cyc(3);
		t_timer;
		t_fill;
		t_write;
		t_nack;
		t_probe;
		t_read;
		give_verdict;
	end
endmodule
